// *** rtl/fast_serial_port.sv ***
// Fast serial port: registers, transmit path, receive path with an
// eight-byte buffer, flow control and block transfers to memory.
// Assumes memory read data arrives the cycle after mem_rd_o.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fast_serial_port
  import fsp_pkg::*;
(
  input logic clk_i,
  input logic rst_n_i,
  input logic ce_i,
  input logic [15:0] addr_i,
  input logic [15:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  output logic [15:0] rdata_o,
  output logic txd_o,
  input logic rxd_i,
  input logic cts_i,
  output logic rts_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input logic [7:0] mem_rdata_i,
  output logic rx_irq_o,
  output logic done_irq_o
);
  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [15:0] cfg_ff;
  logic xoff_ff, txdone_ff, rxdone_ff, ovf_ff;
  logic [12:0] baud_ff;
  logic [7:0] gap_ff;
  logic [15:0] rxptr_ff, txptr_ff;
  logic [9:0] rxcnt_ff, txcnt_ff;
  logic rxblk_ff, txblk_ff;
  logic [7:0] hold_ff;
  logic hold_v_ff, hold_last_ff, hold_blk_ff;
  logic mem_rd_ff, fetch_ff, mem_wr_ff;
  logic [15:0] mem_addr_ff;
  logic [7:0] mem_wdata_ff;
  tx_state_t tx_st_ff;
  logic [8:0] sh_ff, bits_ff, nxt_bits;
  logic cur_last_ff;
  rx_state_t rx_st_ff;
  logic [7:0] rsh_ff, byte_ff;
  logic [2:0] rbit_ff;
  logic byte_v_ff;
  logic [7:0] fifo_mem [8];
  logic [2:0] wp_ff, rp_ff;
  logic [3:0] fcnt_ff;
  logic [15:0] rdata_ff;
  logic rts_ff;
  logic en, rtsp, ctsp, xoffen, ctsen, rxie, doneie, onestop, pktmode;
  logic wr_ctl, wr_baud, wr_gap, wr_dat, wr_rxp, wr_rxc, wr_txp, wr_txc;
  logic rd_dat, tx_tick, rx_tick, flow_ok, tx_start, tx_end, tx_ready;
  logic is_flow, rx_store, push, pop, fifo_full, ovf_set, fetch_go;
  logic [15:0] status;

  assign en = cfg_ff[`B_EN];
  assign rtsp = cfg_ff[`B_RTSP];
  assign ctsp = cfg_ff[`B_CTSP];
  assign xoffen = cfg_ff[`B_XOFFEN];
  assign ctsen = cfg_ff[`B_CTSEN];
  assign rxie = cfg_ff[`B_RXIE];
  assign doneie = cfg_ff[`B_DONEIE];
  assign onestop = cfg_ff[`B_ONESTOP];
  assign pktmode = cfg_ff[`B_PKTMODE];

  // ***************************************************************
  // Register decode
  // ***************************************************************
  assign wr_ctl = ce_i & wr_i & (addr_i == `CTRL_ADDR);
  assign wr_baud = ce_i & wr_i & (addr_i == `BAUD_ADDR);
  assign wr_gap = ce_i & wr_i & (addr_i == `GAP_ADDR);
  assign wr_dat = ce_i & wr_i & (addr_i == `DATA_ADDR);
  assign wr_rxp = ce_i & wr_i & (addr_i == `RXPTR_ADDR);
  assign wr_rxc = ce_i & wr_i & (addr_i == `RXCNT_ADDR);
  assign wr_txp = ce_i & wr_i & (addr_i == `TXPTR_ADDR);
  assign wr_txc = ce_i & wr_i & (addr_i == `TXCNT_ADDR);
  assign rd_dat = ce_i & rd_i & (addr_i == `DATA_ADDR);

  // ***************************************************************
  // Flow and buffer terms
  // ***************************************************************
  assign flow_ok = (~ctsen | (cts_i ^ ctsp)) & ~(xoffen & xoff_ff);
  assign tx_start = en & (tx_st_ff == TX_IDLE) & hold_v_ff & flow_ok;
  assign tx_end = (tx_st_ff == TX_SEND) & tx_tick & (bits_ff == 9'h001);
  // A pending block fetch also keeps software out of the holding byte.
  // A disabled port drops data writes, so it must not claim to be ready.
  assign tx_ready = en & ~hold_v_ff & ~txblk_ff & ~mem_rd_ff & ~fetch_ff;
  assign is_flow = xoffen & ((byte_ff == `XON_CHAR) | (byte_ff == `XOFF_CHAR));
  assign fifo_full = (fcnt_ff == `FIFO_FULL);
  assign rx_store = byte_v_ff & ~is_flow & rxblk_ff;
  assign push = byte_v_ff & ~is_flow & ~rxblk_ff & ~fifo_full;
  assign ovf_set = byte_v_ff & ~is_flow & ~rxblk_ff & fifo_full;
  assign pop = rd_dat & ~rxblk_ff & (fcnt_ff != 4'h0);
  assign fetch_go = en & txblk_ff & ~hold_v_ff & ~mem_rd_ff & ~fetch_ff & ~rx_store;
  assign status = {3'h0, xoff_ff, 4'h0, txdone_ff, rxdone_ff, 1'b0, tx_ready,
                   1'b0, ovf_ff, fifo_full, (fcnt_ff != 4'h0)};

  // ***************************************************************
  // Control and status register
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cfg_ff <= 16'h0000;
    else if (wr_ctl)
      cfg_ff <= wdata_i & `CFG_MASK;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      xoff_ff <= 1'b0;
    else if (ce_i && byte_v_ff && xoffen)
    begin
      if (byte_ff == `XOFF_CHAR)
        xoff_ff <= 1'b1;
      else if (byte_ff == `XON_CHAR)
        xoff_ff <= 1'b0;
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      txdone_ff <= 1'b0;
    else if (ce_i)
      txdone_ff <= (tx_end & cur_last_ff) | (txdone_ff & ~(wr_ctl & wdata_i[`B_TXDONE]));
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rxdone_ff <= 1'b0;
    else if (ce_i)
      rxdone_ff <= (rx_store & (rxcnt_ff == 10'h000))
                   | (rxdone_ff & ~(wr_ctl & wdata_i[`B_RXDONE]));
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ovf_ff <= 1'b0;
    else if (ce_i)
      ovf_ff <= ovf_set | (ovf_ff & ~(wr_ctl & wdata_i[`B_OVF]));
  end

  // ***************************************************************
  // Rate and gap registers
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      baud_ff <= `BAUD_RST;
      gap_ff <= `GAP_RST;
    end
    else
    begin
      if (wr_baud)
        baud_ff <= wdata_i[12:0];
      if (wr_gap)
        gap_ff <= wdata_i[7:0];
    end
  end

  // ***************************************************************
  // Block receive
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rxptr_ff <= 16'h0000;
      rxcnt_ff <= `CNT_IDLE;
      rxblk_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_rxp)
        rxptr_ff <= wdata_i;
      else if (rx_store)
        rxptr_ff <= rxptr_ff + 16'h0001;
      if (wr_rxc)
      begin
        rxcnt_ff <= wdata_i[9:0];
        rxblk_ff <= 1'b1;
      end
      else if (rx_store)
      begin
        // Counting down from zero lands on the idle value by itself.
        rxcnt_ff <= rxcnt_ff - 10'h001;
        if (rxcnt_ff == 10'h000)
          rxblk_ff <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Block transmit
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      txptr_ff <= 16'h0000;
      txcnt_ff <= `CNT_IDLE;
      txblk_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_txp)
        txptr_ff <= wdata_i;
      else if (fetch_ff)
        txptr_ff <= txptr_ff + 16'h0001;
      if (wr_txc)
      begin
        txcnt_ff <= wdata_i[9:0];
        txblk_ff <= 1'b1;
      end
      else if (fetch_ff)
      begin
        txcnt_ff <= txcnt_ff - 10'h001;
        if (txcnt_ff == 10'h000)
          txblk_ff <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Memory port
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_rd_ff <= 1'b0;
      fetch_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 8'h00;
    end
    else if (ce_i)
    begin
      mem_rd_ff <= fetch_go;
      fetch_ff <= mem_rd_ff;
      mem_wr_ff <= rx_store;
      if (fetch_go)
        mem_addr_ff <= txptr_ff;
      else if (rx_store)
      begin
        mem_addr_ff <= rxptr_ff;
        mem_wdata_ff <= byte_ff;
      end
    end
  end

  // ***************************************************************
  // Transmit holding byte
  // ***************************************************************
  // A data write while not ready is dropped so the byte in flight
  // is never overwritten.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_ff <= 8'h00;
      hold_v_ff <= 1'b0;
      hold_last_ff <= 1'b0;
      hold_blk_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!en)
        hold_v_ff <= 1'b0;
      else if (fetch_ff)
      begin
        hold_ff <= mem_rdata_i;
        hold_v_ff <= 1'b1;
        hold_last_ff <= (txcnt_ff == 10'h000);
        hold_blk_ff <= 1'b1;
      end
      else if (wr_dat && tx_ready)
      begin
        hold_ff <= wdata_i[7:0];
        hold_v_ff <= 1'b1;
        hold_last_ff <= 1'b0;
        hold_blk_ff <= 1'b0;
      end
      else if (tx_start)
        hold_v_ff <= 1'b0;
    end
  end

  // ***************************************************************
  // Transmit shifter
  // ***************************************************************
  always_comb
  begin
    if (hold_blk_ff)
      nxt_bits = (gap_ff > `GAP_ONE_STOP) ? (9'(gap_ff - `GAP_BIAS) + `TX_CORE_BITS)
                                         : (`TX_CORE_BITS + 9'h001);
    else
      nxt_bits = `TX_CORE_BITS + (onestop ? 9'h001 : 9'h002);
  end

  bit_tick_gen tx_gen (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(tx_st_ff == TX_SEND),
    .half_i(1'b0),
    .div_i(baud_ff),
    .tick_o(tx_tick)
  );

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_st_ff <= TX_IDLE;
      sh_ff <= 9'h1FF;
      bits_ff <= 9'h000;
      cur_last_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!en)
      begin
        tx_st_ff <= TX_IDLE;
        sh_ff <= 9'h1FF;
      end
      else
      begin
        case (tx_st_ff)
          TX_IDLE:
          begin
            if (tx_start)
            begin
              tx_st_ff <= TX_SEND;
              sh_ff <= {hold_ff, 1'b0};
              bits_ff <= nxt_bits;
              cur_last_ff <= hold_last_ff;
            end
          end
          TX_SEND:
          begin
            if (tx_tick)
            begin
              sh_ff <= {1'b1, sh_ff[8:1]};
              bits_ff <= bits_ff - 9'h001;
              if (bits_ff == 9'h001)
                tx_st_ff <= TX_IDLE;
            end
          end
          default:
            tx_st_ff <= TX_IDLE;
        endcase
      end
    end
  end

  assign txd_o = sh_ff[0];

  // ***************************************************************
  // Receiver
  // ***************************************************************
  bit_tick_gen rx_gen (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(rx_st_ff != RX_IDLE),
    .half_i(1'b1),
    .div_i(baud_ff),
    .tick_o(rx_tick)
  );

  // Any stop length is accepted: after one good stop sample the line
  // is simply watched for the next falling edge.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_st_ff <= RX_IDLE;
      rsh_ff <= 8'h00;
      rbit_ff <= 3'h0;
      byte_v_ff <= 1'b0;
      byte_ff <= 8'h00;
    end
    else if (ce_i)
    begin
      byte_v_ff <= 1'b0;
      if (!en)
        rx_st_ff <= RX_IDLE;
      else
      begin
        case (rx_st_ff)
          RX_IDLE:
          begin
            if (!rxd_i)
            begin
              rx_st_ff <= RX_START;
              rbit_ff <= 3'h0;
            end
          end
          RX_START:
          begin
            if (rx_tick)
              rx_st_ff <= rxd_i ? RX_IDLE : RX_DATA;
          end
          RX_DATA:
          begin
            if (rx_tick)
            begin
              rsh_ff <= {rxd_i, rsh_ff[7:1]};
              rbit_ff <= rbit_ff + 3'h1;
              if (rbit_ff == 3'h7)
                rx_st_ff <= RX_STOP;
            end
          end
          RX_STOP:
          begin
            if (rx_tick)
            begin
              rx_st_ff <= RX_IDLE;
              byte_v_ff <= rxd_i;
              byte_ff <= rsh_ff;
            end
          end
          default:
            rx_st_ff <= RX_IDLE;
        endcase
      end
    end
  end

  // ***************************************************************
  // Receive buffer
  // ***************************************************************
  always_ff @(posedge clk_i)
  begin
    if (ce_i && push)
      fifo_mem[wp_ff] <= byte_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_ff <= 3'h0;
      rp_ff <= 3'h0;
      fcnt_ff <= 4'h0;
    end
    else if (ce_i)
    begin
      if (push)
        wp_ff <= wp_ff + 3'h1;
      if (pop)
        rp_ff <= rp_ff + 3'h1;
      fcnt_ff <= fcnt_ff + {3'h0, push} - {3'h0, pop};
    end
  end

  // ***************************************************************
  // Read port
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_ff <= 16'h0000;
    else if (ce_i)
    begin
      if (!rd_i)
        rdata_ff <= 16'h0000;
      else
      begin
        case (addr_i)
          `CTRL_ADDR: rdata_ff <= cfg_ff | status;
          `BAUD_ADDR: rdata_ff <= {3'h0, baud_ff};
          `GAP_ADDR: rdata_ff <= {8'h00, gap_ff};
          `DATA_ADDR: rdata_ff <= {8'h00, fifo_mem[rp_ff]};
          `RXPTR_ADDR: rdata_ff <= rxptr_ff;
          `RXCNT_ADDR: rdata_ff <= {6'h00, rxcnt_ff};
          `TXPTR_ADDR: rdata_ff <= txptr_ff;
          `TXCNT_ADDR: rdata_ff <= {6'h00, txcnt_ff};
          default: rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // ***************************************************************
  // Handshake and interrupt outputs
  // ***************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rts_ff <= 1'b0;
    else if (ce_i)
      rts_ff <= (en & (~ctsen | rxblk_ff | ~fifo_full)) ^ rtsp;
  end

  assign rts_o = rts_ff;
  assign rdata_o = rdata_ff;
  assign mem_rd_o = mem_rd_ff;
  assign mem_wr_o = mem_wr_ff;
  assign mem_addr_o = mem_addr_ff;
  assign mem_wdata_o = mem_wdata_ff;
  assign rx_irq_o = rxie & (pktmode ? fifo_full : (fcnt_ff != 4'h0));
  assign done_irq_o = doneie & (txdone_ff | rxdone_ff);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  AST_DISABLED_IDLE: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !en) |=> (tx_st_ff == TX_IDLE && rx_st_ff == RX_IDLE && txd_o))
    else $error("Port active while disabled.");

  AST_RTS_LEVEL: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && en && !ctsen) |=> (rts_o != $past(rtsp)))
    else $error("Request-to-send level wrong.");

  AST_CTS_HOLD: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (tx_st_ff == TX_IDLE && ctsen && (cts_i == ctsp)) |=> (tx_st_ff == TX_IDLE))
    else $error("Frame started without clear-to-send.");

  AST_XOFF_HOLD: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (tx_st_ff == TX_IDLE && xoffen && xoff_ff) |=> (tx_st_ff == TX_IDLE))
    else $error("Frame started while paused.");

  AST_TXRDY: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (hold_v_ff || txblk_ff) |-> !status[4])
    else $error("Transmit ready shown while busy.");

  AST_TXDONE_CLR: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wr_ctl && wdata_i[`B_TXDONE] && !(tx_end && cur_last_ff)) |=> !txdone_ff)
    else $error("Transmit done not cleared.");

  AST_OVF_SET: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && ovf_set) |=> (ovf_ff && (fcnt_ff == (`FIFO_FULL - {3'h0, $past(pop)}))))
    else $error("Overflow not flagged.");

  AST_PKT_READ: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && rd_i && addr_i == `CTRL_ADDR) |=> (rdata_o[1] == $past(fcnt_ff == `FIFO_FULL)))
    else $error("Packet ready bit wrong.");

  AST_RXIRQ_GATE: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!rxie || (fcnt_ff == 4'h0)) |-> !rx_irq_o)
    else $error("Receive interrupt without cause.");

  AST_BLK_END: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && rx_store && rxcnt_ff == 10'h000 && !wr_rxc) |=> (rxcnt_ff == `CNT_IDLE && rxdone_ff && !rxblk_ff))
    else $error("Block receive end wrong.");
endmodule

// *** pkg/fsp_defines.svh ***
// Register offsets, field positions, reset values and rate constants
// for the fast serial port. Assumes a 16-bit register port.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

`define CTRL_ADDR 16'hC070
`define BAUD_ADDR 16'hC072
`define GAP_ADDR 16'hC074
`define DATA_ADDR 16'hC076
`define RXPTR_ADDR 16'hC078
`define RXCNT_ADDR 16'hC07A
`define TXPTR_ADDR 16'hC07C
`define TXCNT_ADDR 16'hC07E

`define B_EN 15
`define B_RTSP 14
`define B_CTSP 13
`define B_XOFFEN 11
`define B_CTSEN 10
`define B_RXIE 9
`define B_DONEIE 8
`define B_TXDONE 7
`define B_RXDONE 6
`define B_ONESTOP 5
`define B_PKTMODE 3
`define B_OVF 2
`define CFG_MASK 16'hEF28

`define BAUD_RST 13'h0017
`define GAP_RST 8'h09
`define CNT_IDLE 10'h3FF
`define GAP_BIAS 8'h07
`define GAP_ONE_STOP 8'h08
`define TX_CORE_BITS 9'h009
`define FIFO_FULL 4'h8
`define XON_CHAR 8'h11
`define XOFF_CHAR 8'h13

`define REF_CLK_MHZ 48
`define SYS_CLK_MHZ 10

`endif

// *** pkg/fsp_pkg.sv ***
// Types shared by the fast serial port modules.
// Assumes the defines header is compiled alongside.
package fsp_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// *** rtl/bit_tick_gen.sv ***
// Fractional bit-rate tick generator.
// Assumes a 10 MHz clock and bit rates below it.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module bit_tick_gen
  import fsp_pkg::*;
(
  input logic clk_i,
  input logic rst_n_i,
  input logic ce_i,
  input logic run_i,
  input logic half_i,
  input logic [12:0] div_i,
  output logic tick_o
);
  // The reference rate is not a multiple of the clock, so a phase
  // accumulator spreads the error over bits instead of rounding it.
  logic [16:0] acc_ff;
  logic [16:0] per;
  logic [16:0] sum;

  assign per = 17'(`SYS_CLK_MHZ) * (17'(div_i) + 17'h00001);
  assign sum = acc_ff + 17'(`REF_CLK_MHZ);
  assign tick_o = run_i & (sum >= per);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      acc_ff <= 17'h00000;
    else if (ce_i)
    begin
      if (!run_i)
        acc_ff <= half_i ? (per >> 1) : 17'h00000;
      else if (tick_o)
        acc_ff <= sum - per;
      else
        acc_ff <= sum;
    end
  end
endmodule

// *** verif/remote_dev.sv ***
// Remote serial device: frames bytes onto the receive line and decodes
// frames seen on the transmit line. Assumes five clocks per bit time.
`timescale 1ns/1ps
module remote_dev #(parameter int BIT_CYC = 5)
(
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic hold_i,
  output logic rxd_o,
  output logic cts_o,
  output logic [7:0] got_o,
  output int got_cnt_o
);
  logic [7:0] sh;
  initial
  begin
    rxd_o = 1'b1;
    got_o = 8'h00;
    got_cnt_o = 0;
  end
  assign cts_o = ~hold_i;
  // One start bit, eight data bits with the least significant first, one stop bit.
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++)
    begin
      rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
  // Samples on the falling clock edge, mid-bit, away from the launch edge.
  always
  begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(negedge clk_i);
      sh[i] = txd_i;
    end
    repeat (BIT_CYC) @(negedge clk_i);
    if (txd_i)
    begin
      got_o = sh;
      got_cnt_o++;
    end
  end
endmodule

// *** verif/fast_serial_port_test.sv ***
// Self-checking bench for the fast serial port: register port, serial
// transmit and receive, flow control and receive buffer flags.
// Assumes the remote device model and the reset bit rate of five clocks.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fast_serial_port_test;
  import fsp_pkg::*;
  logic clk_i, rst_n_i, wr_i, rd_i, hold, rxd, cts, txd_o, rts_o;
  logic [15:0] addr_i, wdata_i, rdata_o, v;
  logic [7:0] b;
  logic [7:0] q [8];
  logic rx_irq_o, done_irq_o;
  logic mem_rd, mem_wr;
  logic [15:0] mem_addr, wr_addr;
  logic [7:0] mem_wdata, mem_q, wr_byte;
  logic [31:0] seed;
  int error_cnt, n_tests;
  fast_serial_port dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txd_o(txd_o),
    .rxd_i(rxd), .cts_i(cts), .rts_o(rts_o), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_q), .rx_irq_o(rx_irq_o), .done_irq_o(done_irq_o));
  remote_dev partner_u (.clk_i(clk_i), .txd_i(txd_o), .hold_i(hold), .rxd_o(rxd),
    .cts_o(cts), .got_o(), .got_cnt_o());
  always #50 clk_i = ~clk_i;
  // Memory model: a read returns its low address byte XOR A5 one cycle later, and writes are captured.
  always @(posedge clk_i)
  begin
    if (mem_rd)
      mem_q <= mem_addr[7:0] ^ 8'hA5;
    if (mem_wr)
    begin
      wr_addr <= mem_addr;
      wr_byte <= mem_wdata;
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // The spare edge keeps two writes from lowering and raising the strobe in one step.
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clk_i);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_rx(input int n);
    for (int i = 0; i < 400 && partner_u.got_cnt_o < n; i++)
      @(posedge clk_i);
    if (partner_u.got_cnt_o < n)
    begin
      error_cnt++;
      final_report();
    end
  endtask
  initial
  begin
    clk_i = 0;
    rst_n_i = 0;
    addr_i = 0;
    wdata_i = 0;
    wr_i = 0;
    rd_i = 0;
    hold = 0;
    seed = 32'hE674;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1;
    @(posedge clk_i);
    rd(`CTRL_ADDR);
    chk(v, 16'h0000);
    rd(`BAUD_ADDR);
    chk(v, 16'h0017);
    rd(`GAP_ADDR);
    chk(v, 16'h0009);
    rd(`TXCNT_ADDR);
    chk(v, 16'h03FF);
    rd(16'hC080);
    chk(v, 16'h0000);
    // The divisor keeps its reset value, since the partner model runs at five clocks a bit.
    wr(`BAUD_ADDR, 16'h0017);
    wr(`DATA_ADDR, 16'h00A5);
    repeat (100) @(posedge clk_i);
    chk(partner_u.got_cnt_o[15:0], 16'h0000);
    $display("reset and disable done");
    wr(`CTRL_ADDR, 16'h8020);
    @(posedge clk_i);
    chk({15'h0, rts_o}, 16'h0001);
    wr(`CTRL_ADDR, 16'hC020);
    @(posedge clk_i);
    chk({15'h0, rts_o}, 16'h0000);
    for (int k = 1; k <= 4; k++)
    begin
      b = 8'(rnd());
      rd(`CTRL_ADDR);
      chk(v & 16'h0010, 16'h0010);
      wr(`DATA_ADDR, {8'h00, b});
      wait_rx(k);
      chk({8'h00, partner_u.got_o}, {8'h00, b});
    end
    // Clear-to-send held off must stall the byte until released.
    hold <= 1'b1;
    wr(`CTRL_ADDR, 16'h8420);
    b = 8'(rnd());
    wr(`DATA_ADDR, {8'h00, b});
    repeat (120) @(posedge clk_i);
    chk(partner_u.got_cnt_o[15:0], 16'h0004);
    hold <= 1'b0;
    wait_rx(5);
    chk({8'h00, partner_u.got_o}, {8'h00, b});
    $display("transmit done");
    wr(`CTRL_ADDR, 16'h8200);
    b = 8'(rnd());
    partner_u.send(b);
    repeat (3) @(posedge clk_i);
    chk({15'h0, rx_irq_o}, 16'h0001);
    rd(`CTRL_ADDR);
    chk(v & 16'h0001, 16'h0001);
    rd(`DATA_ADDR);
    chk(v, {8'h00, b});
    chk({15'h0, rx_irq_o}, 16'h0000);
    wr(`CTRL_ADDR, 16'h8208);
    for (int k = 0; k < 8; k++)
    begin
      q[k] = 8'(rnd());
      partner_u.send(q[k]);
      repeat (3) @(posedge clk_i);
      chk({15'h0, rx_irq_o}, {15'h0, k == 7});
    end
    rd(`CTRL_ADDR);
    chk(v & 16'h0007, 16'h0003);
    partner_u.send(8'h3C);
    repeat (3) @(posedge clk_i);
    rd(`CTRL_ADDR);
    chk(v & 16'h0004, 16'h0004);
    wr(`CTRL_ADDR, 16'h820C);
    rd(`CTRL_ADDR);
    chk(v & 16'h0004, 16'h0000);
    for (int k = 0; k < 8; k++)
    begin
      rd(`DATA_ADDR);
      chk(v, {8'h00, q[k]});
    end
    rd(`CTRL_ADDR);
    chk(v & 16'h0003, 16'h0000);
    wr(`CTRL_ADDR, 16'h8800);
    partner_u.send(8'h13);
    repeat (3) @(posedge clk_i);
    rd(`CTRL_ADDR);
    chk(v & 16'h1001, 16'h1000);
    partner_u.send(8'h11);
    repeat (3) @(posedge clk_i);
    rd(`CTRL_ADDR);
    chk(v & 16'h1001, 16'h0000);
    $display("receive done");
    // Block transmit of two bytes with three stop bits; done must not rise before the gap ends.
    wr(`GAP_ADDR, 16'h000A);
    wr(`CTRL_ADDR, 16'h8100);
    wr(`TXPTR_ADDR, 16'h0130);
    wr(`TXCNT_ADDR, 16'h0001);
    rd(`CTRL_ADDR);
    chk(v & 16'h0010, 16'h0000);
    wait_rx(6);
    chk({8'h00, partner_u.got_o}, 16'h0095);
    wait_rx(7);
    chk({8'h00, partner_u.got_o}, 16'h0094);
    repeat (10) @(posedge clk_i);
    chk({15'h0, done_irq_o}, 16'h0000);
    repeat (5) @(posedge clk_i);
    chk({15'h0, done_irq_o}, 16'h0001);
    rd(`CTRL_ADDR);
    chk(v & 16'h0090, 16'h0090);
    rd(`TXCNT_ADDR);
    chk(v, 16'h03FF);
    rd(`TXPTR_ADDR);
    chk(v, 16'h0132);
    wr(`CTRL_ADDR, 16'h8180);
    chk({15'h0, done_irq_o}, 16'h0000);
    // Block receive of one byte goes to memory and leaves the buffer empty.
    wr(`RXPTR_ADDR, 16'h0240);
    wr(`RXCNT_ADDR, 16'h0000);
    b = 8'(rnd());
    partner_u.send(b);
    repeat (3) @(posedge clk_i);
    chk(wr_addr, 16'h0240);
    chk({8'h00, wr_byte}, {8'h00, b});
    chk({15'h0, done_irq_o}, 16'h0001);
    rd(`CTRL_ADDR);
    chk(v & 16'h0041, 16'h0040);
    rd(`RXCNT_ADDR);
    chk(v, 16'h03FF);
    rd(`RXPTR_ADDR);
    chk(v, 16'h0241);
    wr(`CTRL_ADDR, 16'h8140);
    chk({15'h0, done_irq_o}, 16'h0000);
    $display("block transfer done");
    final_report();
  end
endmodule
